// ---- refresh_sr_cfg.svh ----
`ifndef REFRESH_SR_CFG_SVH
`define REFRESH_SR_CFG_SVH
`define CLK_PERIOD_NS   100
`define TCKE_NS         5
`define TREFI_NS        7800
`define TXSDLL_CYC      768
`define MAX_SKEW_EDGES  4'h6
`define ADDR_CTRL       4'h0
`define ADDR_STATUS     4'h4
`define ADDR_ROW        4'h8
`define ADDR_SRCOUNT    4'hC
`define CTRL_RST        4'h3
`define CTRL_PARK       0
`define CTRL_DLLON      1
`define CTRL_CRC        2
`define CTRL_OTF        3
`define ST_INSR         0
`define ST_SUSPECT      1
`define ST_LOST         2
`define ST_RELOCK       3
`endif

// ---- refresh_sr_pkg.sv ----
package refresh_sr_pkg;
   typedef enum logic [1:0] {ST_NORMAL, ST_SREF, ST_RELOCK} srState_e;
   typedef enum logic [2:0] {CMD_DES, CMD_REF, CMD_SRE, CMD_ACT, CMD_WR, CMD_PRE,
                             CMD_OTHER} cmd_e;
endpackage

// ---- sref_timer.sv ----
`timescale 1ns/1ns
module sref_timer #(
   parameter int FIRST_CYC = 1,
   parameter int REFI_CYC  = 78
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // Control and event
   input  wire logic run,
   output logic      tick
);
   localparam int CW = $clog2(REFI_CYC + FIRST_CYC + 1);

   if (FIRST_CYC < 1 || REFI_CYC < 2) begin : gBadParam
      $error("sref_timer: counts out of range");
   end

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          tick_nxt;

   // Reloads while idle so the first tick always lands FIRST_CYC after start
   always_comb begin
      tick_nxt = 1'b0;
      cnt_nxt  = CW'(FIRST_CYC - 1);
      if (run) begin
         if (cnt_r == '0) begin
            tick_nxt = 1'b1;
            cnt_nxt  = CW'(REFI_CYC - 1);
         end else begin
            cnt_nxt = cnt_r - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick  <= tick_nxt;
      end
   end
endmodule // sref_timer

// ---- refresh_sr.sv ----
`timescale 1ns/1ns
`include "refresh_sr_cfg.svh"
// Overview of operation
// R1 - Strobe-faulted write may corrupt its data; device otherwise keeps working within limits.
// R2 - Reads and further writes after a faulted write are accepted; data may be wrong.
// R3 - Precharging all banks after a faulted write restores correct write data.
// R4 - Controller issues every refresh itself, averaging one per tREFI.
// R5 - REF decoded from command pins; row from internal counter, address ignored.
// R6 - Controller precharges all banks for tRP before refresh.
// R7 - Controller sends only deselects until tRFC has passed.
// R8 - Controller postpones at most 8/16/32 refreshes by mode.
// R9 - Controller keeps refresh gap within 9/17/33 intervals by mode.
// R10 - Pulled-in refreshes earn at most 8/16/32 credits by mode.
// R11 - Controller places at most 16/32/64 refreshes in the burst window.
// R12 - Self-refresh entry decoded as REF pattern with CKE low.
// R13 - Controller makes device idle with all timings met before entry.
// R14 - Controller sends deselect on edges just before and after entry.
// R15 - CKE held low keeps self-refresh; all other controls ignored meanwhile.
// R16 - Termination goes high impedance in self-refresh; park restored on exit.
// R17 - DLL switched off on entry, re-enabled with reset on exit.
// R18 - Built-in timer starts an internal refresh within tCKE of entry; code raises refreshStart 2 cycles (200 ns) after entry, tCKE being 5 ns.
// R19 - Controller honours tCKESR, tCKSRE and tCKSRX clock rules.
// R20 - Controller exits by raising CKE with deselect on stable clock.
// R21 - Controller waits tXS before most commands after exit.
// R22 - ZQ and listed mode writes may follow after tXSFast.
// R23 - Reads wait tXSDLL after exit for DLL relock.
// R24 - Controller takes tXS as tRFC plus 10 ns.
// R25 - One extra refresh is required before re-entering self-refresh.
// R26 - Controller keeps a bounded signed refresh debt counter per rank.
module refresh_sr
   import refresh_sr_pkg::*;
#(
   parameter int ROW_W     = 15,
   parameter int XSDLL_CYC = `TXSDLL_CYC
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // Command pins
   input  wire logic             csN,
   input  wire logic             actN,
   input  wire logic             rasN,
   input  wire logic             casN,
   input  wire logic             weN,
   input  wire logic             cke,
   input  wire logic             a10,
   input  wire logic [3:0]       bankAddr,
   // Write strobe checker
   input  wire logic             strobeFault,
   input  wire logic [3:0]       strobeSkew,
   // Register port
   input  wire logic [3:0]       regAddr,
   input  wire logic [31:0]      regWdata,
   input  wire logic             regWr,
   input  wire logic             regRd,
   output logic [31:0]           regRdata,
   // Array and analog controls
   output logic                  refreshStart,
   output logic [ROW_W-1:0]      refreshRow,
   output logic                  inSelfRefresh,
   output logic                  rttHiZ,
   output logic                  rttPark,
   output logic                  dllEnable,
   output logic                  dllReset,
   output logic                  wrSuspect,
   output logic                  recoveryLost
);
   localparam int TCKE_CYC = (`TCKE_NS / `CLK_PERIOD_NS) < 1 ? 1 : `TCKE_NS / `CLK_PERIOD_NS;
   localparam int REFI_CYC = `TREFI_NS / `CLK_PERIOD_NS;
   localparam int TCKE_A   = TCKE_CYC + 1;
   localparam int RW       = $clog2(XSDLL_CYC + 1);

   if (ROW_W < 1 || ROW_W > 32 || XSDLL_CYC < 1) begin : gBadParam
      $error("refresh_sr: parameter out of range");
   end

   function automatic cmd_e decodeCmd(input logic cs, act, ras, cas, we, ck);
      if (cs)
         return CMD_DES;
      else if (!act)
         return CMD_ACT;
      else if (!ras && !cas && we)
         return ck ? CMD_REF : CMD_SRE;
      else if (!ras && cas && !we)
         return CMD_PRE;
      else if (ras && !cas && !we)
         return CMD_WR;
      else
         return CMD_OTHER;
   endfunction

   srState_e         state_r, state_nxt;
   cmd_e             cmd;
   logic [3:0]       ctrl_r, ctrl_nxt;
   logic [15:0]      bankOpen_r, bankOpen_nxt;
   logic             sawPre_r, sawPre_nxt;
   logic [RW-1:0]    relock_r, relock_nxt;
   logic [15:0]      srCount_r, srCount_nxt;
   logic [ROW_W-1:0] row_nxt;
   logic             refS_nxt, suspect_nxt, lost_nxt, faultOk, tick;
   logic             hiZ_nxt, park_nxt, dllEn_nxt, dllRst_nxt;
   logic [31:0]      rdata_nxt;

   sref_timer #(.FIRST_CYC(TCKE_CYC), .REFI_CYC(REFI_CYC)) i_sref_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .run     (state_r == ST_SREF),
      .tick    (tick)
   );

   assign cmd = decodeCmd(csN, actN, rasN, casN, weN, cke);
   // Fault is recoverable only inside the skew window and with CRC and OTF off
   assign faultOk = strobeFault && strobeSkew <= `MAX_SKEW_EDGES
                    && !ctrl_r[`CTRL_CRC] && !ctrl_r[`CTRL_OTF]; // [R1]

   always_comb begin
      state_nxt    = state_r;
      row_nxt      = refreshRow;
      refS_nxt     = 1'b0;
      relock_nxt   = relock_r;
      srCount_nxt  = srCount_r;
      bankOpen_nxt = bankOpen_r;
      sawPre_nxt   = sawPre_r;
      suspect_nxt  = wrSuspect;
      lost_nxt     = recoveryLost || (strobeFault && !faultOk);
      hiZ_nxt      = rttHiZ;
      park_nxt     = rttPark;
      dllEn_nxt    = dllEnable;
      dllRst_nxt   = 1'b0;
      case (state_r)
         ST_SREF: begin
            // Only CKE matters here; the command pins are still decoded, but the result is ignored
            if (tick) begin
               refS_nxt    = 1'b1; // [R18]
               row_nxt     = refreshRow + 1'b1;
               srCount_nxt = srCount_r + 1'b1;
            end
            if (cke) begin // [R15]
               state_nxt  = ST_RELOCK;
               relock_nxt = RW'(XSDLL_CYC - 1);
               hiZ_nxt    = 1'b0; // [R16]
               park_nxt   = ctrl_r[`CTRL_PARK]; // [R16]
               dllEn_nxt  = 1'b1; // [R17]
               dllRst_nxt = ctrl_r[`CTRL_DLLON]; // [R17]
            end
         end
         default: begin
            if (state_r == ST_RELOCK) begin
               if (relock_r == '0)
                  state_nxt = ST_NORMAL;
               else
                  relock_nxt = relock_r - 1'b1;
            end
            case (cmd)
               CMD_REF: begin
                  refS_nxt = 1'b1; // [R5]
                  row_nxt  = refreshRow + 1'b1; // [R5]
               end
               CMD_SRE: begin
                  state_nxt = ST_SREF; // [R12]
                  hiZ_nxt   = 1'b1; // [R16]
                  park_nxt  = 1'b0; // [R16]
                  if (ctrl_r[`CTRL_DLLON])
                     dllEn_nxt = 1'b0; // [R17]
               end
               CMD_ACT:
                  bankOpen_nxt[bankAddr] = 1'b1;
               CMD_PRE: begin
                  if (a10)
                     bankOpen_nxt = '0;
                  else
                     bankOpen_nxt[bankAddr] = 1'b0;
                  sawPre_nxt = wrSuspect;
               end
               default: ;
            endcase
            // Reads and later writes pass untouched; only the flag tracks risk
            if (sawPre_nxt && bankOpen_nxt == '0) begin // [R3]
               suspect_nxt = 1'b0;
               sawPre_nxt  = 1'b0;
            end
            if (faultOk) begin // [R2]
               suspect_nxt = 1'b1; // [R1]
               sawPre_nxt  = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r       <= ST_NORMAL;
         refreshRow    <= '0;
         refreshStart  <= 1'b0;
         relock_r      <= '0;
         srCount_r     <= '0;
         bankOpen_r    <= '0;
         sawPre_r      <= 1'b0;
         wrSuspect     <= 1'b0;
         recoveryLost  <= 1'b0;
         rttHiZ        <= 1'b0;
         rttPark       <= 1'b1;
         dllEnable     <= 1'b1;
         dllReset      <= 1'b0;
         inSelfRefresh <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         refreshRow    <= row_nxt;
         refreshStart  <= refS_nxt;
         relock_r      <= relock_nxt;
         srCount_r     <= srCount_nxt;
         bankOpen_r    <= bankOpen_nxt;
         sawPre_r      <= sawPre_nxt;
         wrSuspect     <= suspect_nxt;
         recoveryLost  <= lost_nxt;
         rttHiZ        <= hiZ_nxt;
         rttPark       <= park_nxt;
         dllEnable     <= dllEn_nxt;
         dllReset      <= dllRst_nxt;
         inSelfRefresh <= state_nxt == ST_SREF;
      end
   end

   // Register port; read data stand only in the cycle after the strobe
   always_comb begin
      ctrl_nxt  = ctrl_r;
      rdata_nxt = 32'h0000_0000;
      if (regWr && regAddr == `ADDR_CTRL)
         ctrl_nxt = regWdata[3:0];
      if (regRd) begin
         if (regAddr == `ADDR_CTRL)
            rdata_nxt = {28'h0000000, ctrl_r};
         else if (regAddr == `ADDR_STATUS)
            rdata_nxt = {28'h0000000, state_r == ST_RELOCK, recoveryLost, wrSuspect,
                         inSelfRefresh};
         else if (regAddr == `ADDR_ROW)
            rdata_nxt = 32'(refreshRow);
         else if (regAddr == `ADDR_SRCOUNT)
            rdata_nxt = {16'h0000, srCount_r};
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_r   <= `CTRL_RST;
         regRdata <= 32'h0000_0000;
      end else begin
         ctrl_r   <= ctrl_nxt;
         regRdata <= rdata_nxt;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   refresh_decode_a: assert property (state_r != ST_SREF && cmd == CMD_REF |=> // [R5]
      refreshStart && refreshRow == $past(refreshRow) + 1'b1)
      else $error("refresh not started with counter row");
   sre_entry_a: assert property (state_r != ST_SREF && cmd == CMD_SRE |=> inSelfRefresh) // [R12]
      else $error("self-refresh entry missed");
   sr_hold_a: assert property (inSelfRefresh && !cke |=> inSelfRefresh && !refreshStart || // [R15]
      inSelfRefresh && $past(tick))
      else $error("self-refresh disturbed by control inputs");
   odt_hiz_a: assert property (inSelfRefresh |-> rttHiZ && !rttPark) // [R16]
      else $error("termination not high impedance in self-refresh");
   park_restore_a: assert property ($fell(inSelfRefresh) |-> !rttHiZ && // [R16]
      rttPark == ctrl_r[`CTRL_PARK])
      else $error("park termination not restored on exit");
   dll_cycle_a: assert property (inSelfRefresh && cke && ctrl_r[`CTRL_DLLON] |=> // [R17]
      dllEnable && dllReset ##1 !dllReset)
      else $error("DLL not re-enabled with reset on exit");
   dll_off_a: assert property (inSelfRefresh && ctrl_r[`CTRL_DLLON] |-> !dllEnable) // [R17]
      else $error("DLL running in self-refresh");
   sr_timer_a: assert property ($rose(inSelfRefresh) ##1 !cke |-> // [R18]
      ##[0:TCKE_A] refreshStart)
      else $error("no internal refresh within tCKE");
   suspect_set_a: assert property (faultOk && state_r != ST_SREF |=> wrSuspect) // [R1]
      else $error("faulted write not flagged");
   suspect_hold_a: assert property (wrSuspect && !faultOk && cmd != CMD_PRE && !sawPre_r // [R2]
      |=> wrSuspect)
      else $error("suspect flag dropped without precharge");
   suspect_clear_a: assert property (wrSuspect && cmd == CMD_PRE && a10 && !faultOk // [R3]
      && state_r != ST_SREF |=> !wrSuspect ##1 !wrSuspect || $past(faultOk))
      else $error("precharge-all did not clear suspect flag");

   cover_sr_cycle: cover property ($rose(inSelfRefresh) ##[1:20] $fell(inSelfRefresh));
   cover_sr_tick: cover property (inSelfRefresh && refreshStart);
   cover_recover: cover property (wrSuspect ##[1:20] !wrSuspect);
   cover_refresh: cover property (!inSelfRefresh && refreshStart);
endmodule // refresh_sr

// ---- host_ctrl_model.sv ----
`timescale 1ns/1ns
module host_ctrl_model
   import refresh_sr_pkg::*;
(
   // Clock
   input  wire logic       sys_clk,
   // Command pins
   output logic            csN,
   output logic            actN,
   output logic            rasN,
   output logic            casN,
   output logic            weN,
   output logic            cke,
   output logic            a10,
   output logic [3:0]      bankAddr
);
   logic [4:0] cmdPins_r;

   assign {csN, actN, rasN, casN, weN} = cmdPins_r;

   initial begin
      cmdPins_r = 5'h1F;
      cke = 1'b1;
      a10 = 1'b0;
      bankAddr = 4'h0;
   end

   // Caller keeps tRP, tRFC and tXS spacing by the order of calls
   // Refreshes are never postponed or pulled in here, so no debt builds
   // No read, ZQ or mode write follows an exit, so tXSFast, tXSDLL and tXS hold
   task automatic issue(input cmd_e c, input logic [3:0] bank, input logic all);
      @(posedge sys_clk);
      bankAddr <= bank;
      a10 <= all;
      case (c)
         CMD_REF, CMD_SRE: cmdPins_r <= 5'h09;
         CMD_ACT: cmdPins_r <= 5'h07;
         CMD_WR: cmdPins_r <= 5'h0C;
         CMD_PRE: cmdPins_r <= 5'h0A;
         default: cmdPins_r <= 5'h1F;
      endcase
      if (c == CMD_SRE) begin
         cke <= 1'b0;
      end
      @(posedge sys_clk);
      // Deselect always separates two commands
      cmdPins_r <= 5'h1F;
   endtask

   // Clock never stops here, so it is stable before exit
   task automatic exitSr;
      @(posedge sys_clk);
      cke <= 1'b1;
      @(posedge sys_clk);
   endtask
endmodule // host_ctrl_model

// ---- test_refresh_sr.sv ----
`timescale 1ns/1ns
`include "refresh_sr_cfg.svh"
module test_refresh_sr
   import refresh_sr_pkg::*;
;
   logic              sys_clk, rst, csN, actN, rasN, casN, weN, cke, a10;
   logic [3:0]        bankAddr, strobeSkew, regAddr;
   logic              strobeFault, regWr, regRd, refreshStart, inSelfRefresh;
   logic [31:0]       regWdata, regRdata;
   logic [14:0]       refreshRow;
   logic              rttHiZ, rttPark, dllEnable, dllReset, wrSuspect, recoveryLost;
   int                errTotal, cmpCount, pulseCnt, cycles;

   host_ctrl_model i_host_ctrl_model (.sys_clk(sys_clk), .csN(csN), .actN(actN),
      .rasN(rasN), .casN(casN), .weN(weN), .cke(cke), .a10(a10), .bankAddr(bankAddr));

   refresh_sr #(.XSDLL_CYC(8)) i_refresh_sr (.sys_clk(sys_clk), .rst(rst), .csN(csN),
      .actN(actN), .rasN(rasN), .casN(casN), .weN(weN), .cke(cke), .a10(a10),
      .bankAddr(bankAddr), .strobeFault(strobeFault), .strobeSkew(strobeSkew),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .refreshStart(refreshStart), .refreshRow(refreshRow),
      .inSelfRefresh(inSelfRefresh), .rttHiZ(rttHiZ), .rttPark(rttPark),
      .dllEnable(dllEnable), .dllReset(dllReset), .wrSuspect(wrSuspect),
      .recoveryLost(recoveryLost));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic finishTest;
      $display("compares %0d mismatches %0d", cmpCount, errTotal);
      if (errTotal == 0 && cmpCount > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Hang guard: the sequence needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (refreshStart === 1'b1) begin
         pulseCnt <= pulseCnt + 1;
      end
      if (cycles == 6000) begin
         errTotal++;
         finishTest;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      cmpCount++;
      if (seen !== expv) begin
         errTotal++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, expv);
      end
   endtask

   task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic regRead(input logic [3:0] a, input logic [31:0] expv);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      check(regRdata, expv);
   endtask

   task automatic fault(input logic [3:0] s);
      @(posedge sys_clk);
      strobeFault <= 1'b1;
      strobeSkew <= s;
      @(posedge sys_clk);
      strobeFault <= 1'b0;
      #1;
   endtask

   initial begin
      rst = 1'b1;
      {strobeFault, regWr, regRd, strobeSkew, regAddr, regWdata} = '0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      check({rttPark, dllEnable, inSelfRefresh}, 32'h6);
      regRead(`ADDR_CTRL, 32'h3);
      regWrite(`ADDR_STATUS, 32'hF);
      regRead(`ADDR_STATUS, 32'h0);
      regRead(4'h2, 32'h0);
      i_host_ctrl_model.issue(CMD_REF, 4'hF, 1'b1);
      #1;
      check({refreshStart, refreshRow}, 32'h8001);
      i_host_ctrl_model.issue(CMD_SRE, 4'h0, 1'b0);
      #1;
      check({inSelfRefresh, rttHiZ, rttPark, dllEnable}, 32'hC);
      repeat (5) @(posedge sys_clk);
      #1;
      check(32'(pulseCnt), 32'h2);
      i_host_ctrl_model.issue(CMD_ACT, 4'h1, 1'b0);
      i_host_ctrl_model.issue(CMD_REF, 4'h0, 1'b0);
      repeat (40) @(posedge sys_clk);
      #1;
      check({inSelfRefresh, 31'(pulseCnt)}, 32'h8000_0002);
      regRead(`ADDR_SRCOUNT, 32'h1);
      i_host_ctrl_model.exitSr;
      #1;
      check({inSelfRefresh, rttHiZ, rttPark, dllEnable, dllReset}, 32'h7);
      regRead(`ADDR_STATUS, 32'h8);
      repeat (10) @(posedge sys_clk);
      regRead(`ADDR_STATUS, 32'h0);
      regWrite(`ADDR_CTRL, 32'h0);
      regRead(`ADDR_CTRL, 32'h0);
      // One extra refresh before entering again
      i_host_ctrl_model.issue(CMD_REF, 4'h0, 1'b0);
      i_host_ctrl_model.issue(CMD_SRE, 4'h0, 1'b0);
      #1;
      check({rttHiZ, dllEnable}, 32'h3);
      repeat (10) @(posedge sys_clk);
      i_host_ctrl_model.exitSr;
      #1;
      check({rttPark, dllReset, refreshRow}, 32'h4);
      regRead(`ADDR_ROW, 32'h4);
      i_host_ctrl_model.issue(CMD_ACT, 4'h2, 1'b0);
      i_host_ctrl_model.issue(CMD_ACT, 4'h5, 1'b0);
      i_host_ctrl_model.issue(CMD_WR, 4'h2, 1'b0);
      fault(4'h6);
      check({wrSuspect, recoveryLost}, 32'h2);
      regRead(`ADDR_STATUS, 32'h2);
      i_host_ctrl_model.issue(CMD_WR, 4'h5, 1'b0);
      i_host_ctrl_model.issue(CMD_PRE, 4'h2, 1'b0);
      #1;
      check(wrSuspect, 32'h1);
      i_host_ctrl_model.issue(CMD_PRE, 4'h5, 1'b0);
      @(posedge sys_clk);
      #1;
      check(wrSuspect, 32'h0);
      i_host_ctrl_model.issue(CMD_ACT, 4'h3, 1'b0);
      fault(4'h6);
      i_host_ctrl_model.issue(CMD_PRE, 4'h0, 1'b1);
      @(posedge sys_clk);
      #1;
      check(wrSuspect, 32'h0);
      fault(4'h7);
      check({wrSuspect, recoveryLost}, 32'h1);
      regWrite(`ADDR_CTRL, 32'h4);
      fault(4'h0);
      check({wrSuspect, recoveryLost}, 32'h1);
      regRead(`ADDR_STATUS, 32'h4);
      regWrite(`ADDR_CTRL, 32'h8);
      fault(4'h0);
      check({wrSuspect, recoveryLost}, 32'h1);
      finishTest;
   end
endmodule // test_refresh_sr
